// ===== logic/bbx_pkg.sv
/*
  Shared constants for the branch and bit instruction executor:
  status flag positions, reset values, register port offsets,
  cycle counts and the decoded operation classes.
  Assumes a 16-bit word-addressed program counter.
*/
package bbx_pkg;
  // ****************************************************************
  // Status flag positions
  // ****************************************************************
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;

  // ****************************************************************
  // Reset values and register port offsets
  // ****************************************************************
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [1:0] RA_STATUS = 2'h0;
  localparam logic [1:0] RA_PC_LO = 2'h1;
  localparam logic [1:0] RA_PC_HI = 2'h2;

  // ****************************************************************
  // Cycle counts
  // ****************************************************************
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_REL_JUMP = 3'h2;
  localparam logic [2:0] CYC_PTR_JUMP = 3'h2;
  localparam logic [2:0] CYC_ABS_JUMP = 3'h3;
  localparam logic [2:0] CYC_REL_CALL = 3'h3;
  localparam logic [2:0] CYC_PTR_CALL = 3'h3;
  localparam logic [2:0] CYC_ABS_CALL = 3'h4;
  localparam logic [2:0] CYC_TAKEN = 3'h2;
  localparam logic [2:0] CYC_IO_BIT = 3'h2;
  localparam logic [15:0] SKIP_ONE = 16'h0002;
  localparam logic [15:0] SKIP_TWO = 16'h0003;

  // ****************************************************************
  // Fixed opcodes and states
  // ****************************************************************
  localparam logic [15:0] OP_PTR_JUMP = 16'h9409;
  localparam logic [15:0] OP_PTR_CALL = 16'h9509;

  typedef enum logic [1:0] {
    ST_READY = 2'b00,
    ST_HOLD = 2'b01,
    ST_IOWR = 2'b10
  } bbx_state_t;

  typedef enum logic [4:0] {
    OPC_NONE, OPC_REL_JUMP, OPC_PTR_JUMP, OPC_ABS_JUMP,
    OPC_REL_CALL, OPC_PTR_CALL, OPC_ABS_CALL, OPC_CMP_SKIP,
    OPC_CMP, OPC_CMP_C, OPC_CMP_I, OPC_SKIP_RBC, OPC_SKIP_RBS,
    OPC_SKIP_IOC, OPC_SKIP_IOS, OPC_BR_SET, OPC_BR_CLR,
    OPC_IO_ONE, OPC_IO_ZERO, OPC_ROL, OPC_ROR, OPC_T_CAP,
    OPC_T_WB, OPC_FLAG_SET, OPC_FLAG_CLR
  } bbx_op_t;
endpackage

// ===== logic/bbx_exec.sv
/*
  Branch and bit instruction executor: decodes one instruction word,
  updates the program counter and status flags, drives register
  and I/O write strobes and holds the issue port for the cycle count.
  Assumes operands, the I/O read value and the Z pointer come from
  logic on the same clock, valid in the issue cycle.
*/
// How it works
// RULE1: pointer jump loads Z, relative jump adds offset plus one, both 2 cycles
// RULE2: pointer call 3, relative call 3, absolute call 4, absolute jump 3 cycles
// RULE3: compare-skip-equal skips next instruction on equal operands, flags kept
// RULE4: compares subtract without storing, update Z N V C H in 1 cycle
// RULE5: skip when selected register bit is zero, 1 to 3 cycles
// RULE6: skip when selected register bit is one, flags kept
// RULE7: skip when addressed I/O bit is zero, flags kept
// RULE8: skip when addressed I/O bit is one
// RULE9: branch on selected flag set adds offset plus one, 1 or 2 cycles
// RULE10: branch on selected flag clear, 1 or 2 cycles, no flag change
// RULE11: unsigned and equality branches test C or Z alone
// RULE12: signed greater-or-equal branch taken when N xor V is zero
// RULE13: signed less-than taken when N xor V is one; minus and plus test N
// RULE14: H, T and V flags each branch when set and when clear
// RULE15: interrupt enable flag branches when one and when zero
// RULE16: I/O bit force-one sets addressed bit in 2 cycles, flags kept
// RULE17: I/O bit force-zero clears addressed bit in 2 cycles, flags kept
// RULE18: rotate left through carry, updates Z C N V in 1 cycle
// RULE19: rotate right through carry, updates Z C N V in 1 cycle
// RULE20: capture selected register bit into T only, 1 cycle
// RULE21: write T into selected register bit, 1 cycle, flags kept
// RULE22: set or clear any one status flag in 1 cycle
// RULE23: I/O bit writes reach addresses 0x00-0x1F and touch only one bit
`timescale 1ns/1ps
module bbx_exec (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_in,
  input wire logic [15:0] instr_ext_in,
  input wire logic next_two_word_in,
  input wire logic [7:0] rd_data_in,
  input wire logic [7:0] rr_data_in,
  input wire logic [15:0] z_ptr_in,
  input wire logic [7:0] io_rd_data_in,
  input wire logic [1:0] bus_addr_in,
  input wire logic [7:0] bus_wdata_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  output logic ready_out,
  output logic claimed_out,
  output logic [4:0] rd_idx_out,
  output logic [4:0] rr_idx_out,
  output logic [4:0] io_addr_out,
  output logic [15:0] pc_out,
  output logic [7:0] status_out,
  output logic io_wr_out,
  output logic [7:0] io_wr_data_out,
  output logic [7:0] io_wr_mask_out,
  output logic reg_wr_out,
  output logic [4:0] reg_wr_idx_out,
  output logic [7:0] reg_wr_data_out,
  output logic push_out,
  output logic [15:0] push_data_out,
  output logic [7:0] bus_rdata_out
);
  import bbx_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Subtract flags; Z chains through the old Z for compare with carry
  function automatic logic [7:0] cmp_flags(input logic [7:0] d,
    input logic [7:0] r, input logic cin, input logic zchain,
    input logic [7:0] old);
    logic [7:0] res;
    logic [7:0] f;
    res = d - r - {7'h00, cin};
    f = old;
    f[FLG_H] = (~d[3] & r[3]) | (r[3] & res[3]) | (res[3] & ~d[3]);
    f[FLG_V] = (d[7] & ~r[7] & ~res[7]) | (~d[7] & r[7] & res[7]);
    f[FLG_N] = res[7];
    f[FLG_Z] = (res == 8'h00) & (zchain ? old[FLG_Z] : 1'b1);
    f[FLG_C] = (~d[7] & r[7]) | (r[7] & res[7]) | (res[7] & ~d[7]);
    f[FLG_S] = f[FLG_N] ^ f[FLG_V];
    return f;
  endfunction

  // Flags after a rotate; H, T and I stay as they were
  function automatic logic [7:0] rot_flags(input logic [7:0] res,
    input logic cout, input logic [7:0] old);
    logic [7:0] f;
    f = old;
    f[FLG_C] = cout;
    f[FLG_Z] = (res == 8'h00);
    f[FLG_N] = res[7];
    f[FLG_V] = res[7] ^ cout;
    f[FLG_S] = f[FLG_N] ^ f[FLG_V];
    return f;
  endfunction

  // ****************************************************************
  // Decode
  // ****************************************************************
  bbx_state_t state;
  bbx_op_t op;
  logic [2:0] wait_cnt;
  logic issue;
  logic [2:0] bit_sel;
  logic [7:0] bit_mask;
  logic [15:0] rel_long;
  logic [15:0] rel_short;
  logic [15:0] skip_step;
  logic flag_hit;
  logic [15:0] next_pc;
  logic [7:0] next_status;
  logic [2:0] next_cyc;
  logic [4:0] io_addr_q;

  assign issue = instr_valid_in & ready_out;
  assign ready_out = (state == ST_READY);
  assign claimed_out = (op != OPC_NONE);
  assign bit_sel = instr_in[2:0];
  assign bit_mask = 8'h01 << bit_sel;
  assign rd_idx_out = (op == OPC_CMP_I) ? {1'b1, instr_in[7:4]} : instr_in[8:4];
  assign rr_idx_out = {instr_in[9], instr_in[3:0]};
  // Only the low 32 I/O locations are reachable by the 5-bit field
  assign io_addr_out = (state == ST_IOWR) ? io_addr_q : instr_in[7:3]; // see RULE23
  assign rel_long = pc_out + {{4{instr_in[11]}}, instr_in[11:0]} + 16'h0001;
  assign rel_short = pc_out + {{9{instr_in[9]}}, instr_in[9:3]} + 16'h0001;
  assign skip_step = next_two_word_in ? SKIP_TWO : SKIP_ONE;
  // Aliased branches are this selected-flag test with a fixed index
  assign flag_hit = status_out[bit_sel]; // see RULE11 RULE12 RULE13 RULE14 RULE15

  // Opcode classification
  always_comb
  begin
    op = OPC_NONE;
    if (instr_in[15:12] == 4'hC)
      op = OPC_REL_JUMP;
    else if (instr_in[15:12] == 4'hD)
      op = OPC_REL_CALL;
    else if (instr_in == OP_PTR_JUMP)
      op = OPC_PTR_JUMP;
    else if (instr_in == OP_PTR_CALL)
      op = OPC_PTR_CALL;
    else if (instr_in[15:9] == 7'h4A && instr_in[3:1] == 3'h6)
      op = OPC_ABS_JUMP;
    else if (instr_in[15:9] == 7'h4A && instr_in[3:1] == 3'h7)
      op = OPC_ABS_CALL;
    else if (instr_in[15:10] == 6'h04)
      op = OPC_CMP_SKIP;
    else if (instr_in[15:10] == 6'h05)
      op = OPC_CMP;
    else if (instr_in[15:10] == 6'h01)
      op = OPC_CMP_C;
    else if (instr_in[15:12] == 4'h3)
      op = OPC_CMP_I;
    else if (instr_in[15:10] == 6'h07 && instr_in[8:4] == rr_idx_out)
      op = OPC_ROL;
    else if (instr_in[15:9] == 7'h4A && instr_in[3:0] == 4'h7)
      op = OPC_ROR;
    else if (instr_in[15:8] == 8'h94 && instr_in[3:0] == 4'h8)
      op = instr_in[7] ? OPC_FLAG_CLR : OPC_FLAG_SET;
    else if (instr_in[15:8] == 8'h98)
      op = OPC_IO_ZERO;
    else if (instr_in[15:8] == 8'h99)
      op = OPC_SKIP_IOC;
    else if (instr_in[15:8] == 8'h9A)
      op = OPC_IO_ONE;
    else if (instr_in[15:8] == 8'h9B)
      op = OPC_SKIP_IOS;
    else if (instr_in[15:11] == 5'h1E)
      op = instr_in[10] ? OPC_BR_CLR : OPC_BR_SET;
    else if (instr_in[15:10] == 6'h3E && !instr_in[3])
      op = instr_in[9] ? OPC_T_CAP : OPC_T_WB;
    else if (instr_in[15:10] == 6'h3F && !instr_in[3])
      op = instr_in[9] ? OPC_SKIP_RBS : OPC_SKIP_RBC;
  end

  // ****************************************************************
  // Next counter, flags and cycle count
  // ****************************************************************
  always_comb
  begin
    next_pc = pc_out + 16'h0001;
    next_status = status_out;
    next_cyc = CYC_ONE;
    case (op)
      OPC_REL_JUMP:
      begin
        next_pc = rel_long; // see RULE1
        next_cyc = CYC_REL_JUMP;
      end
      OPC_PTR_JUMP:
      begin
        next_pc = z_ptr_in; // see RULE1
        next_cyc = CYC_PTR_JUMP;
      end
      OPC_ABS_JUMP:
      begin
        next_pc = instr_ext_in; // see RULE2
        next_cyc = CYC_ABS_JUMP;
      end
      OPC_REL_CALL:
      begin
        next_pc = rel_long; // see RULE2
        next_cyc = CYC_REL_CALL;
      end
      OPC_PTR_CALL:
      begin
        next_pc = z_ptr_in; // see RULE2
        next_cyc = CYC_PTR_CALL;
      end
      OPC_ABS_CALL:
      begin
        next_pc = instr_ext_in; // see RULE2
        next_cyc = CYC_ABS_CALL;
      end
      OPC_CMP_SKIP, OPC_SKIP_RBC, OPC_SKIP_RBS, OPC_SKIP_IOC, OPC_SKIP_IOS:
      begin
        // Skip length follows the size of the instruction skipped
        if ((op == OPC_CMP_SKIP && rd_data_in == rr_data_in) // see RULE3
            || (op == OPC_SKIP_RBC && !rd_data_in[bit_sel]) // see RULE5
            || (op == OPC_SKIP_RBS && rd_data_in[bit_sel]) // see RULE6
            || (op == OPC_SKIP_IOC && !io_rd_data_in[bit_sel]) // see RULE7
            || (op == OPC_SKIP_IOS && io_rd_data_in[bit_sel])) // see RULE8
        begin
          next_pc = pc_out + skip_step;
          next_cyc = skip_step[2:0];
        end
      end
      OPC_CMP:
        next_status = cmp_flags(rd_data_in, rr_data_in, 1'b0, 1'b0, status_out); // see RULE4
      OPC_CMP_C:
        next_status = cmp_flags(rd_data_in, rr_data_in, status_out[FLG_C], 1'b1,
          status_out); // see RULE4
      OPC_CMP_I:
        next_status = cmp_flags(rd_data_in, {instr_in[11:8], instr_in[3:0]}, 1'b0,
          1'b0, status_out); // see RULE4
      OPC_BR_SET, OPC_BR_CLR:
      begin
        if (flag_hit == (op == OPC_BR_SET)) // see RULE9 RULE10
        begin
          next_pc = rel_short;
          next_cyc = CYC_TAKEN;
        end
      end
      OPC_IO_ONE, OPC_IO_ZERO:
        next_cyc = CYC_IO_BIT; // see RULE16 RULE17
      OPC_ROL:
        next_status = rot_flags({rd_data_in[6:0], status_out[FLG_C]}, rd_data_in[7],
          status_out); // see RULE18
      OPC_ROR:
        next_status = rot_flags({status_out[FLG_C], rd_data_in[7:1]}, rd_data_in[0],
          status_out); // see RULE19
      OPC_T_CAP:
        next_status[FLG_T] = rd_data_in[bit_sel]; // see RULE20
      OPC_FLAG_SET:
        next_status[instr_in[6:4]] = 1'b1; // see RULE22
      OPC_FLAG_CLR:
        next_status[instr_in[6:4]] = 1'b0; // see RULE22
      default:
        next_status = status_out;
    endcase
  end

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  // Holds the issue port closed for the remaining cycles
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state <= ST_READY;
      wait_cnt <= 3'h0;
    end
    else if (issue && next_cyc != CYC_ONE)
    begin
      state <= (op == OPC_IO_ONE || op == OPC_IO_ZERO) ? ST_IOWR : ST_HOLD;
      wait_cnt <= next_cyc - CYC_ONE;
    end
    else if (state != ST_READY)
    begin
      wait_cnt <= wait_cnt - 3'h1;
      if (wait_cnt == 3'h1)
        state <= ST_READY;
    end
  end

  // Program counter; an instruction outranks a port write in one cycle
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      pc_out <= PC_RST;
    else if (issue)
      pc_out <= next_pc;
    else if (bus_wr_in && bus_addr_in == RA_PC_LO)
      pc_out[7:0] <= bus_wdata_in;
    else if (bus_wr_in && bus_addr_in == RA_PC_HI)
      pc_out[15:8] <= bus_wdata_in;
  end

  // Status flags, software writable through the port
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      status_out <= STATUS_RST;
    else if (issue)
      status_out <= next_status;
    else if (bus_wr_in && bus_addr_in == RA_STATUS)
      status_out <= bus_wdata_in;
  end

  // Read-modify-write of one I/O bit; the mask lets peripherals ignore
  // the other bits so write-one-to-clear flags there are not disturbed
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      io_wr_out <= 1'b0;
      io_addr_q <= 5'h00;
      io_wr_data_out <= 8'h00;
      io_wr_mask_out <= 8'h00;
    end
    else
    begin
      io_wr_out <= issue && (op == OPC_IO_ONE || op == OPC_IO_ZERO);
      if (issue && (op == OPC_IO_ONE || op == OPC_IO_ZERO))
      begin
        io_addr_q <= instr_in[7:3];
        io_wr_mask_out <= bit_mask; // see RULE23
        io_wr_data_out <= (op == OPC_IO_ONE) ? (io_rd_data_in | bit_mask) // see RULE16
          : (io_rd_data_in & ~bit_mask); // see RULE17
      end
    end
  end

  // Register write-back for rotates and T write-back
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      reg_wr_out <= 1'b0;
      reg_wr_idx_out <= 5'h00;
      reg_wr_data_out <= 8'h00;
    end
    else
    begin
      reg_wr_out <= issue && (op == OPC_ROL || op == OPC_ROR || op == OPC_T_WB);
      if (issue)
      begin
        reg_wr_idx_out <= instr_in[8:4];
        if (op == OPC_ROL)
          reg_wr_data_out <= {rd_data_in[6:0], status_out[FLG_C]}; // see RULE18
        else if (op == OPC_ROR)
          reg_wr_data_out <= {status_out[FLG_C], rd_data_in[7:1]}; // see RULE19
        else if (op == OPC_T_WB)
          reg_wr_data_out <= status_out[FLG_T] ? (rd_data_in | bit_mask) // see RULE21
            : (rd_data_in & ~bit_mask);
      end
    end
  end

  // Return address handed to the stack logic outside
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      push_out <= 1'b0;
      push_data_out <= 16'h0000;
    end
    else
    begin
      push_out <= issue && (op == OPC_REL_CALL || op == OPC_PTR_CALL || op == OPC_ABS_CALL);
      if (issue)
        push_data_out <= pc_out + ((op == OPC_ABS_CALL) ? 16'h0002 : 16'h0001);
    end
  end

  // Register port read data, one cycle after the strobe
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      bus_rdata_out <= 8'h00;
    else if (bus_rd_in && bus_addr_in == RA_STATUS)
      bus_rdata_out <= status_out;
    else if (bus_rd_in && bus_addr_in == RA_PC_LO)
      bus_rdata_out <= pc_out[7:0];
    else if (bus_rd_in && bus_addr_in == RA_PC_HI)
      bus_rdata_out <= pc_out[15:8];
    else
      bus_rdata_out <= 8'h00;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  property p_rel_jump;
    issue && op == OPC_REL_JUMP |=> !ready_out && pc_out == $past(pc_out)
      + {{4{$past(instr_in[11])}}, $past(instr_in[11:0])} + 16'h0001 ##1 ready_out;
  endproperty
  a_rel_jump: assert property (p_rel_jump) else $error("relative jump wrong"); // see RULE1

  property p_ptr_call;
    issue && op == OPC_PTR_CALL |=> push_out && pc_out == $past(z_ptr_in)
      ##0 !ready_out [*2] ##1 ready_out;
  endproperty
  a_ptr_call: assert property (p_ptr_call) else $error("pointer call wrong"); // see RULE2

  property p_abs_call;
    issue && op == OPC_ABS_CALL |=> !ready_out [*3] ##1 ready_out;
  endproperty
  a_abs_call: assert property (p_abs_call) else $error("absolute call timing"); // see RULE2

  property p_skip_equal;
    issue && op == OPC_CMP_SKIP && rd_data_in == rr_data_in && !next_two_word_in
      |=> pc_out == $past(pc_out) + 16'h0002 && $stable(status_out) ##1 ready_out;
  endproperty
  a_skip_equal: assert property (p_skip_equal) else $error("skip equal wrong"); // see RULE3

  property p_compare;
    issue && op == OPC_CMP |=> ready_out && !reg_wr_out
      && status_out[FLG_Z] == ($past(rd_data_in) == $past(rr_data_in))
      && status_out[FLG_C] == ($past(rd_data_in) < $past(rr_data_in));
  endproperty
  a_compare: assert property (p_compare) else $error("compare flags wrong"); // see RULE4

  property p_skip_io;
    issue && op == OPC_SKIP_IOS && !io_rd_data_in[bit_sel]
      |=> ready_out && pc_out == $past(pc_out) + 16'h0001;
  endproperty
  a_skip_io: assert property (p_skip_io) else $error("io skip wrong"); // see RULE8

  property p_branch_clear;
    issue && op == OPC_BR_CLR && !flag_hit
      |=> !ready_out && $stable(status_out) ##1 ready_out;
  endproperty
  a_branch_clear: assert property (p_branch_clear) else $error("branch timing"); // see RULE10

  property p_io_one;
    issue && op == OPC_IO_ONE |=> io_wr_out && io_wr_mask_out == $past(bit_mask)
      && (io_wr_data_out & io_wr_mask_out) == io_wr_mask_out ##1 !io_wr_out && ready_out;
  endproperty
  a_io_one: assert property (p_io_one) else $error("io bit set wrong"); // see RULE16

  property p_rol;
    issue && op == OPC_ROL |=> reg_wr_out && status_out[FLG_C] == $past(rd_data_in[7])
      && reg_wr_data_out == {$past(rd_data_in[6:0]), $past(status_out[FLG_C])};
  endproperty
  a_rol: assert property (p_rol) else $error("rotate left wrong"); // see RULE18

  property p_t_capture;
    issue && op == OPC_T_CAP |=> status_out[FLG_T] == $past(rd_data_in[bit_sel])
      && status_out[5:0] == $past(status_out[5:0]);
  endproperty
  a_t_capture: assert property (p_t_capture) else $error("T capture wrong"); // see RULE20
endmodule

// ===== dv/bbx_tb.sv
/*
  Self-checking bench for the branch and bit instruction executor.
  It issues one instruction at a time and uses the register port.
  The bench plays the register file, the I/O space and the Z pointer
  itself, so operand values are driven beside each instruction word.
*/
`timescale 1ns/1ps
module testbench;
  import bbx_pkg::*;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic instr_valid_in = 1'b0;
  logic [15:0] instr_in = 16'h0000;
  logic [15:0] instr_ext_in = 16'h0000;
  logic next_two_word_in = 1'b0;
  logic [7:0] rd_data_in = 8'h00;
  logic [7:0] rr_data_in = 8'h00;
  logic [15:0] z_ptr_in = 16'h0000;
  logic [7:0] io_rd_data_in = 8'h00;
  logic [1:0] bus_addr_in = 2'h0;
  logic [7:0] bus_wdata_in = 8'h00;
  logic bus_wr_in = 1'b0;
  logic bus_rd_in = 1'b0;
  logic ready_out, io_wr_out, reg_wr_out, push_out, claimed_out;
  logic [4:0] io_addr_out, reg_wr_idx_out, rd_idx_out, rr_idx_out;
  logic [15:0] pc_out, push_data_out;
  logic [7:0] status_out, io_wr_data_out, io_wr_mask_out, reg_wr_data_out, bus_rdata_out;
  logic [15:0] pc_c, st_c, iod_c, iom_c, ioa_c, rwd_c, pshd_c, rdv;
  logic iow_c, rw_c, psh_c;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int sk, exp_n, tk;
  logic [15:0] sk_op [5] = '{16'h1012, 16'hFC05, 16'hFE05, 16'h99FD, 16'h9BFD};

  bbx_exec i_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .instr_valid_in(instr_valid_in),
    .instr_in(instr_in), .instr_ext_in(instr_ext_in), .next_two_word_in(next_two_word_in),
    .rd_data_in(rd_data_in), .rr_data_in(rr_data_in), .z_ptr_in(z_ptr_in),
    .io_rd_data_in(io_rd_data_in), .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in),
    .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in), .ready_out(ready_out),
    .claimed_out(claimed_out), .rd_idx_out(rd_idx_out), .rr_idx_out(rr_idx_out),
    .io_addr_out(io_addr_out), .pc_out(pc_out),
    .status_out(status_out), .io_wr_out(io_wr_out), .io_wr_data_out(io_wr_data_out),
    .io_wr_mask_out(io_wr_mask_out), .reg_wr_out(reg_wr_out),
    .reg_wr_idx_out(reg_wr_idx_out), .reg_wr_data_out(reg_wr_data_out),
    .push_out(push_out), .push_data_out(push_data_out), .bus_rdata_out(bus_rdata_out));

  // ****************************************************************
  // Clock and hang guard
  // ****************************************************************
  initial
  begin
    forever #2.5 mclk_in = ~mclk_in;
  end

  // Generous ceiling: the full sequence needs under 600 cycles
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      results();
    end
  end

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    bus_wr_in <= 1'b1;
    bus_addr_in <= a;
    bus_wdata_in <= d;
    @(posedge mclk_in);
    bus_wr_in <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a);
    @(posedge mclk_in);
    bus_rd_in <= 1'b1;
    bus_addr_in <= a;
    @(posedge mclk_in);
    bus_rd_in <= 1'b0;
    #1;
    rdv = {8'h00, bus_rdata_out};
  endtask

  task automatic setpc(input logic [15:0] p);
    wr(RA_PC_LO, p[7:0]);
    wr(RA_PC_HI, p[15:8]);
  endtask

  // Issue one instruction, capture results after the taking edge, count busy cycles
  task automatic run(input logic [15:0] ins, input logic [15:0] ext, input logic [7:0] a,
    input logic [7:0] b, input logic [7:0] io, input logic tw, input int ncyc);
    int n;
    @(posedge mclk_in);
    instr_valid_in <= 1'b1;
    instr_in <= ins;
    instr_ext_in <= ext;
    rd_data_in <= a;
    rr_data_in <= b;
    io_rd_data_in <= io;
    next_two_word_in <= tw;
    @(posedge mclk_in);
    instr_valid_in <= 1'b0;
    #1;
    pc_c = pc_out;
    st_c = {8'h00, status_out};
    iow_c = io_wr_out;
    iod_c = {8'h00, io_wr_data_out};
    iom_c = {8'h00, io_wr_mask_out};
    ioa_c = {11'h000, io_addr_out};
    rw_c = reg_wr_out;
    rwd_c = {3'h0, reg_wr_idx_out, reg_wr_data_out};
    psh_c = push_out;
    pshd_c = push_data_out;
    n = 1;
    while (ready_out !== 1'b1 && n < 8)
    begin
      @(posedge mclk_in);
      #1;
      n++;
    end
    chk(16'(n), 16'(ncyc));
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (16) @(posedge mclk_in);
    nrst_in <= 1'b1;
    rd(RA_STATUS);
    chk(rdv, 16'h0000);
    rd(2'h3);
    chk(rdv, 16'h0000);
    // Control transfers keep the flags; absolute forms need the second word
    wr(RA_STATUS, 8'h5A);
    setpc(16'h0200);
    run(16'hC7FF, 16'h0000, 8'h00, 8'h00, 8'h00, 1'b0, 2);
    chk(pc_c, 16'h0A00);
    run(16'hCFFF, 16'h0000, 8'h00, 8'h00, 8'h00, 1'b0, 2);
    chk(pc_c, 16'h0A00);
    z_ptr_in <= 16'h1234;
    run(OP_PTR_JUMP, 16'h0000, 8'h00, 8'h00, 8'h00, 1'b0, 2);
    chk(pc_c, 16'h1234);
    run(16'h940C, 16'hBEEF, 8'h00, 8'h00, 8'h00, 1'b0, 3);
    chk(pc_c, 16'hBEEF);
    run(16'hD010, 16'h0000, 8'h00, 8'h00, 8'h00, 1'b0, 3);
    chk(pc_c, 16'hBF00);
    chk({psh_c, pshd_c[14:0]}, {1'b1, 15'h3EF0});
    z_ptr_in <= 16'h4321;
    run(OP_PTR_CALL, 16'h0000, 8'h00, 8'h00, 8'h00, 1'b0, 3);
    chk(pc_c, 16'h4321);
    run(16'h940E, 16'h0055, 8'h00, 8'h00, 8'h00, 1'b0, 4);
    chk(pc_c, 16'h0055);
    chk(st_c, 16'h005A);
    // Every skip kind, with the condition both ways and a one- or two-word successor
    for (int k = 0; k < 5; k++)
      for (int v = 0; v < 2; v++)
        for (int t = 0; t < 2; t++)
        begin
          sk = (k == 1 || k == 3) ? !v : v;
          exp_n = sk ? 2 + t : 1;
          wr(RA_STATUS, 8'hA5);
          setpc(16'h0300);
          run(sk_op[k], 16'h0000, v ? 8'h20 : 8'hDF, 8'h20, v ? 8'h20 : 8'hDF, t[0],
            exp_n);
          chk(pc_c, 16'h0300 + 16'(exp_n));
          chk(st_c, 16'h00A5);
        end
    // Branch on each flag index, set and clear forms, offset minus three
    for (int s = 0; s < 8; s++)
      for (int f = 0; f < 2; f++)
        for (int v = 0; v < 2; v++)
        begin
          tk = (f == 0) ? v : !v;
          wr(RA_STATUS, 8'(v << s));
          setpc(16'h0100);
          run(16'hF3E8 | 16'(f << 10) | 16'(s), 16'h0000, 8'h00, 8'h00, 8'h00, 1'b0,
            tk ? 2 : 1);
          chk(pc_c, tk ? 16'h00FE : 16'h0101);
          chk(st_c, 16'(v << s));
        end
    // Compares: flags from the subtraction, nothing stored; signed branch follows
    wr(RA_STATUS, 8'h00);
    run(16'h1501, 16'h0000, 8'h80, 8'h01, 8'h00, 1'b0, 1);
    chk({15'h0000, rw_c}, 16'h0000);
    chk(st_c, 16'h0038);
    run(16'hF3E4, 16'h0000, 8'h00, 8'h00, 8'h00, 1'b0, 2);
    run(16'hF7E4, 16'h0000, 8'h00, 8'h00, 8'h00, 1'b0, 1);
    run(16'h3505, 16'h0000, 8'h55, 8'h00, 8'h00, 1'b0, 1);
    chk(st_c, 16'h0002);
    chk({5'h00, claimed_out, rd_idx_out, rr_idx_out}, {6'h01, 5'h10, 5'h05});
    wr(RA_STATUS, 8'h03);
    run(16'h0501, 16'h0000, 8'h10, 8'h0F, 8'h00, 1'b0, 1);
    chk(st_c, 16'h0022);
    // I/O bit writes at the top bit-addressable location touch one bit only
    wr(RA_STATUS, 8'h3C);
    run(16'h9AFB, 16'h0000, 8'h00, 8'h00, 8'h81, 1'b0, 2);
    chk({2'h0, iow_c, iom_c[7:0], ioa_c[4:0]}, {3'h1, 8'h08, 5'h1F});
    chk(iod_c, 16'h0089);
    run(16'h98FB, 16'h0000, 8'h00, 8'h00, 8'hFF, 1'b0, 2);
    chk({2'h0, iow_c, iom_c[7:0], ioa_c[4:0]}, {3'h1, 8'h08, 5'h1F});
    chk(iod_c, 16'h00F7);
    chk(st_c, 16'h003C);
    // Rotates through carry
    wr(RA_STATUS, 8'h01);
    run(16'h1C55, 16'h0000, 8'h80, 8'h80, 8'h00, 1'b0, 1);
    chk({rw_c, rwd_c[12:0]}, {1'b1, 5'h05, 8'h01});
    chk(st_c, 16'h0019);
    wr(RA_STATUS, 8'h00);
    run(16'h9457, 16'h0000, 8'h01, 8'h01, 8'h00, 1'b0, 1);
    chk({rw_c, rwd_c[12:0]}, {1'b1, 5'h05, 8'h00});
    chk(st_c, 16'h001B);
    // T flag capture of a one, write-back, then capture of a zero
    run(16'hFA37, 16'h0000, 8'h80, 8'h80, 8'h00, 1'b0, 1);
    chk(st_c, 16'h005B);
    run(16'hF840, 16'h0000, 8'hF0, 8'hF0, 8'h00, 1'b0, 1);
    chk({2'h0, rw_c, rwd_c[12:0]}, {3'h1, 5'h04, 8'hF1});
    chk(st_c, 16'h005B);
    wr(RA_STATUS, 8'hFF);
    run(16'hFA37, 16'h0000, 8'h7F, 8'h7F, 8'h00, 1'b0, 1);
    chk(st_c, 16'h00BF);
    // Set then clear each single flag
    wr(RA_STATUS, 8'h00);
    for (int s = 0; s < 8; s++)
    begin
      run(16'h9408 | 16'(s << 4), 16'h0000, 8'h00, 8'h00, 8'h00, 1'b0, 1);
      chk(st_c, 16'(1 << s));
      run(16'h9488 | 16'(s << 4), 16'h0000, 8'h00, 8'h00, 8'h00, 1'b0, 1);
      chk(st_c, 16'h0000);
    end
    // Unmapped writes are dropped; PC bytes read back separately
    wr(2'h3, 8'hFF);
    setpc(16'hA55A);
    rd(RA_PC_LO);
    chk(rdv, 16'h005A);
    rd(RA_PC_HI);
    chk(rdv, 16'h00A5);
    rd(RA_STATUS);
    chk(rdv, 16'h0000);
    results();
  end
endmodule
